// >>> nhc_cfg.svh
`ifndef NHC_CFG_SVH
`define NHC_CFG_SVH

// command opcodes
`define NHC_OP_READ1      8'h00
`define NHC_OP_MOVE_RD    8'h35
`define NHC_OP_RAND_IN    8'h85
`define NHC_OP_DUMMY      8'h11
`define NHC_OP_PROG1      8'h80
`define NHC_OP_PROG2      8'h81
`define NHC_OP_PROG_GO    8'h10
`define NHC_OP_ERASE      8'h60
`define NHC_OP_ERASE_GO   8'hd0
`define NHC_OP_STATUS     8'h70
`define NHC_OP_PD_STATUS  8'h78
`define NHC_OP_RESET      8'hff

// status bits
`define NHC_ST_FAIL       0
`define NHC_ST_FAIL_PREV  1
`define NHC_ST_DONE       5
`define NHC_ST_READY      6

// address cycle counts
`define NHC_FULL_ADDR_CYC 3'h5
`define NHC_BLK_ADDR_CYC  3'h3

// apb register offsets
`define NHC_REG_CTRL      12'h000
`define NHC_REG_SRC0      12'h004
`define NHC_REG_SRC1      12'h008
`define NHC_REG_DST0      12'h00c
`define NHC_REG_DST1      12'h010
`define NHC_REG_STATUS    12'h014
`define NHC_REG_RESULT    12'h018
`define NHC_REG_COLUMN    12'h01c

// ctrl fields: [2:0] opcode of job, [8] start (self clearing)
`define NHC_CTRL_START    8

// strobe timing: cycles each strobe phase lasts
`define NHC_STROBE_NS     30
`define NHC_STROBE_CYC    ((`NHC_STROBE_NS + 9) / 10)

`endif

// >>> nhc_pkg.sv
package nhc_pkg;
  typedef enum logic [2:0] {
    NHC_JOB_MOVE   = 3'h1,
    NHC_JOB_ERASE  = 3'h2,
    NHC_JOB_PDSTAT = 3'h3,
    NHC_JOB_STATUS = 3'h4,
    NHC_JOB_RESET  = 3'h5
  } nhc_job_type;

  // one bus cycle kind on the flash link
  typedef enum logic [1:0] {
    NHC_CYC_CMD  = 2'h0,
    NHC_CYC_ADDR = 2'h1,
    NHC_CYC_READ = 2'h2
  } nhc_cyc_type;
endpackage

// >>> nhc_host.sv
// Operation
// - internal move runs read-for-move sequence, then program-for-move sequence
// - each moved page is programmed back into the plane it came from
// - read-for-move: 00h, five addresses, 00h, five addresses, 35h
// - program-for-move: 85h, five addresses, 11h; device busy dummy time
// - during dummy busy only status read or reset may be issued
// - then 80h, five second-plane addresses, 10h starts programming
// - on failure bit 0, read per-plane status once per plane
// - random data input may change column during either plane's data input
// - two-plane erase uses different planes, same die, page address zero
// - erase: 60h, three addresses, 60h, three addresses, D0h
// - 78h takes three addresses; top bit picks die, low bit picks plane
// - per-die status read allowed except after two-plane page read
// - plain status read forbidden around interleaved die operations
// - no per-die status read around power-on reset or otp commands
// - interleave: command die 0 first, then die 1 while busy
`timescale 1ns/1ps
`include "nhc_cfg.svh"

module nhc_host (
  // system
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash link
  output logic             chip_enable_n,
  output logic             cmd_latch,
  output logic             addr_latch,
  output logic             write_enable_n,
  output logic             read_enable_n,
  input  wire logic        ready_busy_n,
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out,
  output logic             io_oe
);
  import nhc_pkg::*;

  localparam int unsigned STROBE = `NHC_STROBE_CYC;

  logic       rst_s1_q, rst_s2_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // software registers
  logic [2:0]  job_q;
  logic [39:0] src0_q, src1_q, dst0_q, dst1_q;
  logic [15:0] column_q;
  logic [7:0]  result_q;
  logic        busy_q, start_q;

  // sequencer program: up to 13 link cycles per job phase
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_PULSE = 6'b000100,
    ST_HOLD  = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_DONE  = 6'b100000
  } nhc_state_type;
  nhc_state_type state_q;

  logic [4:0]  step_q;
  logic [3:0]  tick_q;
  logic [1:0]  phase_q;
  nhc_cyc_type cyc_kind;
  logic [7:0]  cyc_byte;
  logic        cyc_last;
  logic        cyc_wait;

  function automatic logic [7:0] addr_byte(input logic [39:0] a, input logic [4:0] i);
    addr_byte = a[8*i +: 8];
  endfunction

  // one table lookup: returns kind, byte, whether to wait on busy after, last
  always_comb begin
    cyc_kind = NHC_CYC_CMD;
    cyc_byte = `NHC_OP_STATUS;
    cyc_wait = 1'b0;
    cyc_last = 1'b0;
    unique case (job_q)
      NHC_JOB_MOVE: begin
        if (phase_q == 2'h0) begin
          if (step_q == 5'd0 || step_q == 5'd6) begin
            cyc_byte = `NHC_OP_READ1;
          end else if (step_q == 5'd12) begin
            cyc_byte = `NHC_OP_MOVE_RD;
            cyc_wait = 1'b1;
          end else if (step_q < 5'd6) begin
            cyc_kind = NHC_CYC_ADDR;
            cyc_byte = addr_byte({src0_q[23:0], column_q}, step_q - 5'd1);
          end else begin
            cyc_kind = NHC_CYC_ADDR;
            cyc_byte = addr_byte({src1_q[23:0], column_q}, step_q - 5'd7);
          end
        end else if (phase_q == 2'h1) begin
          if (step_q == 5'd0) begin
            cyc_byte = `NHC_OP_RAND_IN;
          end else if (step_q == 5'd6) begin
            cyc_byte = `NHC_OP_DUMMY;
            cyc_wait = 1'b1;
          end else begin
            cyc_kind = NHC_CYC_ADDR;
            cyc_byte = addr_byte({dst0_q[23:0], column_q}, step_q - 5'd1);
          end
        end else begin
          if (step_q == 5'd0) begin
            cyc_byte = `NHC_OP_PROG1;
          end else if (step_q == 5'd6) begin
            cyc_byte = `NHC_OP_PROG_GO;
            cyc_wait = 1'b1;
            cyc_last = 1'b1;
          end else begin
            cyc_kind = NHC_CYC_ADDR;
            cyc_byte = addr_byte({dst1_q[23:0], column_q}, step_q - 5'd1);
          end
        end
      end
      NHC_JOB_ERASE: begin
        if (step_q == 5'd0 || step_q == 5'd4) begin
          cyc_byte = `NHC_OP_ERASE;
        end else if (step_q == 5'd8) begin
          cyc_byte = `NHC_OP_ERASE_GO;
          cyc_wait = 1'b1;
          cyc_last = 1'b1;
        end else if (step_q < 5'd4) begin
          // row bytes sit in the low three lanes, so die bit is reachable
          cyc_kind = NHC_CYC_ADDR;
          cyc_byte = addr_byte(src0_q, step_q - 5'd1);
        end else begin
          cyc_kind = NHC_CYC_ADDR;
          cyc_byte = addr_byte(src1_q, step_q - 5'd5);
        end
      end
      NHC_JOB_PDSTAT: begin
        if (step_q == 5'd0) begin
          cyc_byte = `NHC_OP_PD_STATUS;
        end else if (step_q == 5'd4) begin
          cyc_kind = NHC_CYC_READ;
          cyc_last = 1'b1;
        end else begin
          cyc_kind = NHC_CYC_ADDR;
          cyc_byte = addr_byte(src0_q, step_q - 5'd1);
        end
      end
      NHC_JOB_STATUS: begin
        if (step_q == 5'd0) begin
          cyc_byte = `NHC_OP_STATUS;
        end else begin
          cyc_kind = NHC_CYC_READ;
          cyc_last = 1'b1;
        end
      end
      default: begin
        cyc_byte = `NHC_OP_RESET;
        cyc_wait = 1'b1;
        cyc_last = 1'b1;
      end
    endcase
  end

  // step bookkeeping: last step of move phase 0 or 1 steps to the next move phase
  logic phase_end;
  assign phase_end = cyc_wait && !cyc_last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      step_q  <= 5'd0;
      phase_q <= 2'h0;
      tick_q  <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          step_q  <= 5'd0;
          phase_q <= 2'h0;
          tick_q  <= 4'h0;
          if (start_q) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          tick_q <= tick_q + 4'h1;
          if (tick_q == 4'(STROBE - 1)) begin
            tick_q  <= 4'h0;
            state_q <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          tick_q <= tick_q + 4'h1;
          if (tick_q == 4'(STROBE - 1)) begin
            tick_q  <= 4'h0;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          tick_q <= tick_q + 4'h1;
          if (tick_q == 4'(STROBE - 1)) begin
            tick_q <= 4'h0;
            if (cyc_wait) begin
              state_q <= ST_WAIT;
            end else if (cyc_last) begin
              state_q <= ST_DONE;
            end else begin
              step_q  <= step_q + 5'd1;
              state_q <= ST_SETUP;
            end
          end
        end
        ST_WAIT: begin
          // busy line takes a few cycles to fall; leave once it reads high after 16 cycles in wait
          tick_q <= (tick_q == 4'hf) ? tick_q : tick_q + 4'h1;
          if (tick_q == 4'hf && ready_busy_n) begin
            tick_q <= 4'h0;
            if (phase_end) begin
              phase_q <= phase_q + 2'h1;
              step_q  <= 5'd0;
              state_q <= ST_SETUP;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // link pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_enable_n  <= 1'b1;
      cmd_latch      <= 1'b0;
      addr_latch     <= 1'b0;
      write_enable_n <= 1'b1;
      read_enable_n  <= 1'b1;
      io_out         <= 8'h00;
      io_oe          <= 1'b0;
    end else begin
      chip_enable_n  <= (state_q == ST_IDLE) || (state_q == ST_DONE);
      cmd_latch      <= (state_q != ST_IDLE) && (cyc_kind == NHC_CYC_CMD);
      addr_latch     <= (state_q != ST_IDLE) && (cyc_kind == NHC_CYC_ADDR);
      write_enable_n <= !((state_q == ST_PULSE) && (cyc_kind != NHC_CYC_READ));
      read_enable_n  <= !((state_q == ST_PULSE) && (cyc_kind == NHC_CYC_READ));
      io_out         <= cyc_byte;
      io_oe          <= (state_q != ST_IDLE) && (cyc_kind != NHC_CYC_READ);
    end
  end

  // status byte sampled at end of read pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 8'h00;
    end else if (state_q == ST_HOLD && tick_q == 4'h0 && cyc_kind == NHC_CYC_READ) begin
      result_q <= io_in;
    end
  end

  // apb register file
  logic apb_wr, apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;
  assign busy_q = (state_q != ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      job_q    <= NHC_JOB_STATUS;
      src0_q   <= 40'h0;
      src1_q   <= 40'h0;
      dst0_q   <= 40'h0;
      dst1_q   <= 40'h0;
      column_q <= 16'h0;
      start_q  <= 1'b0;
    end else begin
      if (state_q == ST_SETUP) begin
        start_q <= 1'b0;
      end
      if (apb_wr && !busy_q) begin
        unique case (paddr)
          `NHC_REG_CTRL: begin
            job_q   <= nhc_job_type'(pwdata[2:0]);
            start_q <= pwdata[`NHC_CTRL_START];
          end
          `NHC_REG_SRC0:   src0_q   <= {8'h00, pwdata};
          `NHC_REG_SRC1:   src1_q   <= {8'h00, pwdata};
          `NHC_REG_DST0:   dst0_q   <= {8'h00, pwdata};
          `NHC_REG_DST1:   dst1_q   <= {8'h00, pwdata};
          `NHC_REG_COLUMN: column_q <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (apb_rd && !penable) begin
      pslverr <= 1'b0;
      unique case (paddr)
        `NHC_REG_CTRL:   prdata <= {23'h0, start_q, 5'h0, job_q};
        `NHC_REG_SRC0:   prdata <= src0_q[31:0];
        `NHC_REG_SRC1:   prdata <= src1_q[31:0];
        `NHC_REG_DST0:   prdata <= dst0_q[31:0];
        `NHC_REG_DST1:   prdata <= dst1_q[31:0];
        `NHC_REG_STATUS: prdata <= {30'h0, ready_busy_n, busy_q};
        `NHC_REG_RESULT: prdata <= {24'h0, result_q};
        `NHC_REG_COLUMN: prdata <= {16'h0, column_q};
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      pslverr <= !(paddr inside {`NHC_REG_CTRL, `NHC_REG_SRC0, `NHC_REG_SRC1, `NHC_REG_DST0,
                                 `NHC_REG_DST1, `NHC_REG_STATUS, `NHC_REG_RESULT, `NHC_REG_COLUMN});
    end
  end
endmodule

// >>> nhc_host_properties.sv
`timescale 1ns/1ps
module nhc_host_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chip_enable_n,
  input wire logic        cmd_latch,
  input wire logic        addr_latch,
  input wire logic        write_enable_n,
  input wire logic        read_enable_n,
  input wire logic        ready_busy_n,
  input wire logic [7:0]  io_out,
  input wire logic        io_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_we_pulse_len: assert property ($fell(write_enable_n) |-> ##1 !write_enable_n [*2] ##1 write_enable_n)
    else $error("write strobe not three cycles");
  a_re_pulse_len: assert property ($fell(read_enable_n) |-> ##1 !read_enable_n [*2] ##1 read_enable_n)
    else $error("read strobe not three cycles");
  a_strobe_excl: assert property (!(!write_enable_n && !read_enable_n))
    else $error("both strobes low");
  a_drive_on_write: assert property (!write_enable_n |-> io_oe && !chip_enable_n)
    else $error("write strobe without drive");
  a_release_on_read: assert property (!read_enable_n |-> !io_oe && !chip_enable_n && !cmd_latch && !addr_latch)
    else $error("read strobe while driving");
  a_hold_stable: assert property ($rose(write_enable_n) |-> $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch))
    else $error("cycle changed at strobe edge");
  a_busy_cmds: assert property ($fell(write_enable_n) && !ready_busy_n |-> cmd_latch && io_out inside {8'h70, 8'h78, 8'hff})
    else $error("illegal cycle while busy");
  a_confirm_wait: assert property ($rose(write_enable_n) && cmd_latch && io_out inside {8'h35, 8'h11, 8'h10, 8'hd0}
    |-> write_enable_n [*8] ##1 write_enable_n [*8])
    else $error("strobe too soon after confirm");
  a_unmapped_err: assert property (psel && penable && !pwrite && paddr > 12'h01c |-> pready && pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  c_move: cover property ($rose(write_enable_n) && cmd_latch && io_out == 8'h35);
  c_erase: cover property ($rose(write_enable_n) && cmd_latch && io_out == 8'hd0);
  c_pdstat: cover property ($rose(write_enable_n) && cmd_latch && io_out == 8'h78);
endmodule

bind nhc_host nhc_host_chk u_chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable_n(chip_enable_n),
  .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_enable_n(write_enable_n),
  .read_enable_n(read_enable_n), .ready_busy_n(ready_busy_n), .io_out(io_out), .io_oe(io_oe));

// >>> nhc_dev_model.sv
`timescale 1ns/1ps
module nhc_dev_model #(
  parameter int         T_RD = 400,
  parameter int         T_DB = 200,
  parameter int         T_PG = 800,
  parameter int         T_ER = 1000,
  parameter logic [3:0] FAILM = 4'h4
) (
  input  wire logic       chip_enable_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_enable_n,
  input  wire logic       read_enable_n,
  input  wire logic [7:0] io_out,
  output logic            ready_busy_n,
  output logic [7:0]      io_in,
  output int              bad_cnt
);
  logic [1:0] busy = 0;
  logic [1:0] unit = 0;
  logic [7:0] last = 0;
  logic [7:0] st;
  logic       dbsy = 0;
  logic       sel78 = 0;
  logic [7:0] a0 = 0, a1 = 0, a2 = 0;
  int         t;
  initial bad_cnt = 0;
  assign ready_busy_n = ~|busy;
  // per-unit view after 78h, die 0 busy with fail of any of the four units otherwise
  assign st = sel78 ? {1'b0, {2{~busy[unit[1]]}}, 4'h0, FAILM[unit]}
                    : {1'b0, {2{~busy[0]}}, 4'h0, |FAILM};
  // released bus shows the inverse of the last byte, never a stale copy
  assign io_in = (!chip_enable_n && !read_enable_n) ? st : ~last;
  always @(posedge read_enable_n) last = st;
  task automatic go(input logic d, input int tt, input logic db);
    busy[d] = 1;
    dbsy = db;
    #tt;
    busy[d] = 0;
    dbsy = 0;
  endtask
  always @(posedge write_enable_n) if (!chip_enable_n) begin
    if (cmd_latch) begin
      if (busy != 0 && !(io_out inside {8'h70, 8'hff}) && (dbsy || io_out != 8'h78))
        bad_cnt++;
      sel78 = (io_out == 8'h78);
      case (io_out)
        8'h35: t = T_RD;
        8'h11: t = T_DB;
        8'h10: t = T_PG;
        8'hd0: t = T_ER;
        8'hff: t = T_DB;
        default: t = 0;
      endcase
      if (t > 0) fork go(unit[1], t, io_out == 8'h11); join_none
    end else if (addr_latch) begin
      // the last three address bytes are always the row bytes
      a2 = a1;
      a1 = a0;
      a0 = io_out;
      unit = {a0[2], a2[6]};
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "nhc_cfg.svh"
module testbench;
  import nhc_pkg::*;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v, b;
  logic [31:0] w[1:4];
  logic [15:0] col;
  logic        pready, pslverr, chip_enable_n, cmd_latch, addr_latch, write_enable_n, read_enable_n;
  logic        ready_busy_n, io_oe;
  logic [7:0]  io_in, io_out;
  int          failures = 0, num_checks = 0, bad_cnt;
  logic [33:0] exp_apb[$];
  logic [8:0]  exp_link[$];
  always #5 clk = ~clk;
  nhc_host dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable_n(chip_enable_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n), .ready_busy_n(ready_busy_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  nhc_dev_model dev (.chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_enable_n(write_enable_n), .read_enable_n(read_enable_n), .io_out(io_out),
    .ready_busy_n(ready_busy_n), .io_in(io_in), .bad_cnt(bad_cnt));
  task check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task rdc(input logic [11:0] a, input logic [32:0] e);
    exp_apb.push_back({1'b1, e});
    apb(0, a, 0);
  endtask
  task cmd(input logic [7:0] c, input logic [39:0] a, input int n);
    exp_link.push_back({1'b1, c});
    for (int k = 0; k < n; k++) exp_link.push_back({1'b0, a[8*k +: 8]});
  endtask
  task start(input nhc_job_type j);
    apb(1, `NHC_REG_CTRL, {23'h0, 1'b1, 5'h0, j});
  endtask
  task wait_idle;
    do begin
      exp_apb.push_back(34'h0);
      apb(0, `NHC_REG_STATUS, 0);
    end while (rd[0] !== 1'b0);
  endtask
  // a read result is compared as its handshake edge arrives
  always @(posedge clk) if (psel && penable && pready && !pwrite) begin
    logic [33:0] e;
    e = exp_apb.pop_front();
    if (e[33]) check({pslverr, prdata}, e[32:0]);
  end
  // each link cycle as the device latches it; 80h and 81h are both legal
  always @(posedge write_enable_n) if (chip_enable_n === 1'b0)
    check({24'h0, cmd_latch, (cmd_latch && io_out == 8'h81) ? 8'h80 : io_out},
          {24'h0, exp_link.size() > 0 ? exp_link.pop_front() : 9'h1ff});
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(87));
    repeat (2) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    rdc(`NHC_REG_STATUS, 33'h2);
    rdc(12'h020, 33'h1_0000_0000);
    v = $urandom;
    col = v[15:0];
    apb(1, `NHC_REG_COLUMN, v);
    rdc(`NHC_REG_COLUMN, {17'h0, col});
    // sources and destinations on planes 0,1,0,1 of die 0
    for (int i = 1; i <= 4; i++) begin
      w[i] = ($urandom & 32'hfffb_ffbf) | (32'(1 - i % 2) << 6);
      apb(1, 12'(4 * i), w[i]);
    end
    cmd(8'h00, {w[1][23:0], col}, 5); cmd(8'h00, {w[2][23:0], col}, 5); cmd(8'h35, 0, 0);
    cmd(8'h85, {w[3][23:0], col}, 5); cmd(8'h11, 0, 0);
    cmd(8'h80, {w[4][23:0], col}, 5); cmd(8'h10, 0, 0);
    start(NHC_JOB_MOVE);
    wait_idle();
    cmd(8'h70, 0, 0);
    start(NHC_JOB_STATUS);
    wait_idle();
    rdc(`NHC_REG_RESULT, 33'h61);
    // writes while busy must be dropped
    // page bits, plane bit and die bit cleared; second block on plane 1
    v = $urandom & 32'hfffb_ff80;
    apb(1, `NHC_REG_SRC0, v);
    apb(1, `NHC_REG_SRC1, v | 32'h40);
    cmd(8'h60, v, 3); cmd(8'h60, v | 32'h40, 3); cmd(8'hd0, 0, 0);
    start(NHC_JOB_ERASE);
    apb(1, `NHC_REG_SRC0, ~v);
    rdc(`NHC_REG_SRC0, {1'b0, v});
    wait_idle();
    for (int u = 0; u < 4; u++) begin
      b = ($urandom & 32'hbb) | (32'(u % 2) << 6) | (32'(u / 2) << 2);
      apb(1, `NHC_REG_SRC0, {4{b[7:0]}});
      cmd(8'h78, {4{b[7:0]}}, 3);
      start(NHC_JOB_PDSTAT);
      wait_idle();
      rdc(`NHC_REG_RESULT, {25'h0, 7'h30, dev.FAILM[u]});
    end
    cmd(8'hff, 0, 0);
    start(NHC_JOB_RESET);
    wait_idle();
    check(33'(exp_link.size()), 33'h0);
    check(33'(bad_cnt), 33'h0);
    print_verdict();
  end
endmodule
